// >>> rtl/pfa_pkg.sv
// Package for the program flash access port: register map, fields, timing
package pfa_pkg;
	localparam int          ADDR_W          = 12;
	localparam logic [11:0] OFF_ADDR_LOW    = 12'h000;
	localparam logic [11:0] OFF_ADDR_HIGH   = 12'h004;
	localparam logic [11:0] OFF_DATA_LOW    = 12'h008;
	localparam logic [11:0] OFF_DATA_HIGH   = 12'h00c;
	localparam logic [11:0] OFF_CONTROL     = 12'h010;
	localparam logic [11:0] OFF_UNLOCK      = 12'h014;
	localparam logic [7:0]  KEY_FIRST       = 8'h55;
	localparam logic [7:0]  KEY_SECOND      = 8'haa;
	localparam logic [7:0]  RESET_BYTE      = 8'h00;
	localparam logic [5:0]  DATA_HIGH_MASK  = 6'h3f;
	localparam int          CTL_RD          = 0;
	localparam int          CTL_WR          = 1;
	localparam int          CTL_PERMIT      = 2;
	localparam int          CTL_FAULT       = 3;
	localparam int          CTL_FREE        = 4;
	localparam int          CTL_LATCH       = 5;
	localparam int          CTL_CFG_SEL     = 6;
	localparam int          CTL_TOP         = 7;
	localparam logic [1:0]  READ_IGNORE     = 2'h2;
	localparam logic [31:0] PAD_ZERO        = 32'h0000_0000;
	typedef enum logic [1:0] {UNLK_IDLE, UNLK_HALF, UNLK_OPEN} pfa_unlock_t;
endpackage : pfa_pkg

// >>> rtl/pfa_port.sv
// Program flash access port: APB register file, unlock sequencer, read engine
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ns
// Notes on behaviour
// RULE_01 - Address bits 7:0 from low byte
// RULE_02 - Address bits 14:8 from high byte bits 6:0
// RULE_03 - High byte bit 7 ignores writes, reads one
// RULE_04 - Write starts only after 55h then AAh
// RULE_05 - Unlock judged only by unlock register writes; the code also re-locks on any control register write
// RULE_06 - Software loads address, clears config select, reads
// RULE_07 - Unimplemented bits read zero, top ones read one
// RULE_08 - Read waits two cycles, clears start, latches data
module pfa_port (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [pfa_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	output logic      [14:0]               flash_word_address,
	output logic                           config_space_select,
	output logic                           flash_read_strobe,
	input  wire logic [13:0]               flash_data_value,
	output logic                           flash_program_strobe,
	output logic                           latch_only_select,
	output logic                           erase_select
);
	import pfa_pkg::*;

	logic [7:0]  addr_low_reg;
	logic [6:0]  addr_high_reg;
	logic [7:0]  data_low_reg;
	logic [5:0]  data_high_reg;
	logic        rd_reg;
	logic        wr_reg;
	logic        permit_reg;
	logic        fault_reg;
	logic        free_reg;
	logic        latch_reg;
	logic        cfg_sel_reg;
	logic [1:0]  wait_reg;
	logic        prog_pulse_reg;
	pfa_unlock_t unlock_reg;
	pfa_unlock_t unlock_next;
	logic [31:0] rdata_reg;

	wire        access    = psel & penable;
	wire        wr_access = access & pwrite;
	wire        rd_access = access & ~pwrite;
	wire        hit_low   = paddr == OFF_ADDR_LOW;
	wire        hit_high  = paddr == OFF_ADDR_HIGH;
	wire        hit_dlow  = paddr == OFF_DATA_LOW;
	wire        hit_dhigh = paddr == OFF_DATA_HIGH;
	wire        hit_ctl   = paddr == OFF_CONTROL;
	wire        hit_key   = paddr == OFF_UNLOCK;
	wire        mapped    = hit_low | hit_high | hit_dlow | hit_dhigh | hit_ctl | hit_key;
	wire        wr_low    = wr_access & hit_low;
	wire        wr_high   = wr_access & hit_high;
	wire        wr_dlow   = wr_access & hit_dlow;
	wire        wr_dhigh  = wr_access & hit_dhigh;
	wire        wr_ctl    = wr_access & hit_ctl;
	wire        wr_key    = wr_access & hit_key;
	wire [7:0]  wbyte     = pwdata[7:0];
	wire        busy      = rd_reg | wr_reg;
	wire        read_go   = wr_ctl & wbyte[CTL_RD] & ~busy;
	wire        write_req = wr_ctl & wbyte[CTL_WR] & ~wbyte[CTL_RD] & ~busy;
	wire        unlocked  = unlock_reg == UNLK_OPEN;
	wire        write_go  = write_req & permit_reg & unlocked; // [RULE_04]
	wire        write_bad = write_req & ~write_go;             // [RULE_04]
	wire        read_done = rd_reg & (wait_reg == READ_IGNORE);
	wire [7:0]  ctl_view  = {1'b1, cfg_sel_reg, latch_reg, free_reg, fault_reg,
		permit_reg, wr_reg, rd_reg};                           // [RULE_07]
	wire [7:0]  high_view = {1'b1, addr_high_reg};             // [RULE_03]
	wire [7:0]  dhigh_view = {2'b00, data_high_reg};           // [RULE_07]
	wire [7:0]  read_byte =
		hit_low   ? addr_low_reg :
		hit_high  ? high_view :
		hit_dlow  ? data_low_reg :
		hit_dhigh ? dhigh_view :
		hit_ctl   ? ctl_view : RESET_BYTE;                     // [RULE_07]

	assign pready               = 1'b1;
	assign pslverr              = access & ~mapped;
	assign prdata               = rdata_reg;
	assign flash_word_address   = {addr_high_reg, addr_low_reg}; // [RULE_01] [RULE_02]
	assign config_space_select  = cfg_sel_reg;
	assign flash_read_strobe    = rd_reg & (wait_reg == 2'h0);
	assign flash_program_strobe = prog_pulse_reg;
	assign latch_only_select    = latch_reg;
	assign erase_select         = free_reg;

	// Unlock sequencer: any other unlock value or a control write re-locks
	always_comb begin
		unlock_next = unlock_reg;
		if (wr_key) begin
			case (unlock_reg)                                      // [RULE_05]
				UNLK_IDLE: unlock_next = (wbyte == KEY_FIRST) ? UNLK_HALF : UNLK_IDLE;
				UNLK_HALF: unlock_next = (wbyte == KEY_SECOND) ? UNLK_OPEN :
					(wbyte == KEY_FIRST) ? UNLK_HALF : UNLK_IDLE;
				UNLK_OPEN: unlock_next = (wbyte == KEY_FIRST) ? UNLK_HALF : UNLK_IDLE;
				default:   unlock_next = UNLK_IDLE;
			endcase
		end else if (wr_ctl) begin
			unlock_next = UNLK_IDLE;                               // [RULE_05]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlock_reg <= UNLK_IDLE;
		end else begin
			unlock_reg <= unlock_next;
		end
	end

	// Address registers; bit 7 of the high byte is not stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_low_reg  <= RESET_BYTE;
			addr_high_reg <= RESET_BYTE[6:0];
		end else begin
			if (wr_low) addr_low_reg <= wbyte;                   // [RULE_01]
			if (wr_high) addr_high_reg <= wbyte[6:0];            // [RULE_02] [RULE_03]
		end
	end

	// Control register and read engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_reg         <= 1'b0;
			wr_reg         <= 1'b0;
			permit_reg     <= 1'b0;
			fault_reg      <= 1'b0;
			free_reg       <= 1'b0;
			latch_reg      <= 1'b0;
			cfg_sel_reg    <= 1'b0;
			wait_reg       <= 2'h0;
			prog_pulse_reg <= 1'b0;
		end else begin
			prog_pulse_reg <= write_go;                          // [RULE_04]
			if (wr_ctl & ~busy) begin
				permit_reg <= wbyte[CTL_PERMIT];
				free_reg   <= wbyte[CTL_FREE];
				latch_reg  <= wbyte[CTL_LATCH];
				cfg_sel_reg <= wbyte[CTL_CFG_SEL];               // [RULE_06]
			end
			if (write_bad) fault_reg <= 1'b1;
			else if (wr_ctl & ~wbyte[CTL_FAULT]) fault_reg <= 1'b0;
			if (read_go) begin
				rd_reg   <= 1'b1;
				wait_reg <= 2'h0;
			end else if (read_done) begin
				rd_reg   <= 1'b0;                                // [RULE_08]
			end else if (rd_reg) begin
				wait_reg <= wait_reg + 2'h1;                     // [RULE_08]
			end
			wr_reg <= write_go;
		end
	end

	// Data registers: fetched word latched at end of read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_low_reg  <= RESET_BYTE;
			data_high_reg <= RESET_BYTE[5:0];
		end else if (read_done) begin
			data_low_reg  <= flash_data_value[7:0];              // [RULE_08]
			data_high_reg <= flash_data_value[13:8];             // [RULE_08]
		end else begin
			if (wr_dlow) data_low_reg <= wbyte;
			if (wr_dhigh) data_high_reg <= wbyte[5:0] & DATA_HIGH_MASK;
		end
	end

	// Read data captured at the setup edge (psel high, penable low)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= PAD_ZERO;
		end else if (psel & ~penable & ~pwrite) begin
			rdata_reg <= {PAD_ZERO[31:8], read_byte};            // [RULE_07]
		end
	end
endmodule : pfa_port

// >>> verif/pfa_props.sv
// Checker for the program flash access port
`timescale 1ns/1ns
module pfa_props (
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [pfa_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                 pwdata,
	input wire logic [31:0]                 prdata,
	input wire logic [14:0]                 flash_word_address,
	input wire logic                        flash_read_strobe,
	input wire logic                        flash_program_strobe
);
	import pfa_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr_acc = psel && penable && pwrite;
	wire rd_acc = psel && penable && !pwrite;
	wire ctl_rd = wr_acc && paddr == OFF_CONTROL && pwdata[CTL_RD];
	wire ctl_wr = wr_acc && paddr == OFF_CONTROL && pwdata[CTL_WR];
	addr_low_a: assert property (wr_acc && paddr == OFF_ADDR_LOW |=>
		flash_word_address[7:0] == $past(pwdata[7:0])) else $error("low address wrong");
	addr_high_a: assert property (wr_acc && paddr == OFF_ADDR_HIGH |=>
		flash_word_address[14:8] == $past(pwdata[6:0])) else $error("high address wrong");
	high_top_a: assert property (rd_acc && paddr == OFF_ADDR_HIGH |-> prdata[7])
		else $error("high address bit 7 not one");
	data_pad_a: assert property (rd_acc && paddr == OFF_DATA_HIGH |-> prdata[31:6] == 0)
		else $error("data high padding not zero");
	key_read_a: assert property (rd_acc && paddr == OFF_UNLOCK |-> prdata == 0)
		else $error("unlock key readable");
	read_cause_a: assert property (flash_read_strobe |-> $past(ctl_rd))
		else $error("read strobe without start");
	read_gap_a: assert property (flash_read_strobe |=> !flash_read_strobe [*2])
		else $error("read strobe repeated");
	prog_cause_a: assert property (flash_program_strobe |-> $past(ctl_wr) || $past(ctl_wr, 2))
		else $error("program strobe without start");
	cover property (ctl_rd);
	cover property (flash_program_strobe);
	cover property (rd_acc && paddr == OFF_ADDR_HIGH);
endmodule : pfa_props
bind pfa_port pfa_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.flash_word_address(flash_word_address), .flash_read_strobe(flash_read_strobe),
	.flash_program_strobe(flash_program_strobe));

// >>> verif/tb.sv
// Self-checking bench for the program flash access port
`timescale 1ns/1ns
module tb;
	import pfa_pkg::*;
	logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0, prdata, q;
	logic              pready, pslverr, e, cfg, rstb, pstb, lat, ers;
	logic [14:0]       fwa;
	logic [13:0]       fdv = 14'h3fa5;
	int                errors = 0, total_checks = 0, cycles = 0, pulses = 0;
	pfa_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flash_word_address(fwa), .config_space_select(cfg),
		.flash_read_strobe(rstb), .flash_data_value(fdv), .flash_program_strobe(pstb),
		.latch_only_select(lat), .erase_select(ers));
	initial begin
		forever #2 pclk = ~pclk;
	end
	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : report_and_stop
	always @(posedge pclk) begin
		cycles++;
		if (pstb === 1'b1) pulses++;
		if (cycles == 3000) begin
			errors++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0);
		chk(q, x);
	endtask : rd
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFF_ADDR_HIGH, 32'h80);
		rd(OFF_CONTROL, 32'h80);
		wr(OFF_ADDR_LOW, 32'h34);
		wr(OFF_ADDR_HIGH, 32'h12);
		rd(OFF_ADDR_HIGH, 32'h92);
		chk(32'(fwa), 32'h1234);
		wr(OFF_CONTROL, 32'h70);
		chk(32'({lat, ers, cfg}), 32'h7);
		wr(OFF_CONTROL, 32'h01);
		chk(32'({rstb, cfg}), 32'h2);
		rd(OFF_CONTROL, 32'h81);
		do xfer(1'b0, OFF_CONTROL, 32'h0); while (q[0] !== 1'b0);
		rd(OFF_DATA_LOW, 32'ha5);
		rd(OFF_DATA_HIGH, 32'h3f);
		wr(OFF_DATA_LOW, 32'h5a);
		rd(OFF_DATA_LOW, 32'h5a);
		wr(OFF_DATA_HIGH, 32'hd2);
		rd(OFF_DATA_HIGH, 32'h12);
		rd(OFF_UNLOCK, 32'h0);
		rd(12'h020, 32'h0);
		chk(32'(e), 32'h1);
		wr(OFF_CONTROL, 32'h04);
		wr(OFF_UNLOCK, 32'haa);
		wr(OFF_UNLOCK, 32'h55);
		wr(OFF_CONTROL, 32'h06);
		rd(OFF_CONTROL, 32'h8c);
		wr(OFF_CONTROL, 32'h04);
		wr(OFF_UNLOCK, 32'h55);
		wr(OFF_ADDR_LOW, 32'haa);
		wr(OFF_CONTROL, 32'h06);
		rd(OFF_CONTROL, 32'h8c);
		wr(OFF_CONTROL, 32'h04);
		wr(OFF_UNLOCK, 32'h55);
		wr(OFF_UNLOCK, 32'haa);
		wr(OFF_CONTROL, 32'h06);
		repeat (3) @(posedge pclk);
		chk(32'(pulses), 32'h1);
		report_and_stop();
	end
endmodule : tb
